// >>> logic/fpc_cfg.svh
// fpc_cfg.svh - register offsets, field positions and reset values of the pin
// function block. assumes 32-bit classic wishbone, byte addresses, word aligned.
`ifndef FPC_CFG_SVH
`define FPC_CFG_SVH

// ==========================================================================
// register byte offsets
`define FPC_OFS_STATUS   8'h00
`define FPC_OFS_CONFIG   8'h04
`define FPC_OFS_TXDATA   8'h08
`define FPC_OFS_RXDATA   8'h0c
`define FPC_OFS_PINSTAT  8'h10

// ==========================================================================
// status register fields
`define FPC_ST_SWD       7
`define FPC_ST_QE        6
`define FPC_ST_BP_HI     5
`define FPC_ST_BP_LO     2
`define FPC_ST_RST       8'h00

// ==========================================================================
// config register fields
`define FPC_CF_PFS       0
`define FPC_CF_DRIVE     1
`define FPC_CF_RST       2'h0

// ==========================================================================
// pin status register fields
`define FPC_PS_SEL       0
`define FPC_PS_PAUSE     1
`define FPC_PS_HWRST     2
`define FPC_PS_REFUSED   3
`define FPC_PS_RXVALID   4
`define FPC_PS_ROLE_LO   5
`define FPC_PS_ROLE_HI   6

// ==========================================================================
// serial engine
`define FPC_BYTE_BITS    8
`define FPC_TX_RST       8'hff

`endif

// >>> logic/fpc_pkg.sv
// fpc_pkg.sv - types of the pin function block.
// assumes fpc_cfg.svh supplies the numeric constants.
package fpc_pkg;

  // ==========================================================================
  // role of the shared pause / reset / data line 3 pin
  typedef enum logic [1:0] {
    FPC_ROLE_PAUSE,
    FPC_ROLE_RESET,
    FPC_ROLE_DATA3
  } fpc_role_type;

  // ==========================================================================
  // serial engine state
  typedef enum logic [1:0] {
    FPC_SER_IDLE,
    FPC_SER_SHIFT,
    FPC_SER_PAUSE
  } fpc_ser_type;

endpackage

// >>> logic/fpc_sync.sv
// fpc_sync.sv - two flop synchroniser for a group of pin levels.
// assumes the inputs are asynchronous to clk_sys; only stage two is visible.
`timescale 1ns/1ps
module fpc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // ==========================================================================
  // two stages; the first is read by the second only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_r   <= INIT;
      sync_out <= INIT;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // fpc_sync

// >>> logic/fpc_pin_function.sv
// fpc_pin_function.sv - pin function control of a serial flash: write protect,
// quad data lines, pause and hardware reset on the shared pin, serial shifter.
// assumes sck is far slower than clk_sys (at least 4 clk_sys per sck phase).
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "fpc_cfg.svh"
module fpc_pin_function #(
  parameter bit SEPARATE_RESET_PIN = 1'b0
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst,
  // wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // serial control pins
  input  wire logic               ce_n,
  input  wire logic               sck,
  input  wire logic               hw_reset_n,
  // data line 0 (serial in)
  input  wire logic               io0_i,
  output logic                    io0_o,
  output logic                    io0_oe,
  // data line 1 (serial out)
  input  wire logic               io1_i,
  output logic                    io1_o,
  output logic                    io1_oe,
  // write protect / data_line_2
  input  wire logic               io2_i,
  output logic                    io2_o,
  output logic                    io2_oe,
  // pause or reset / data_line_3
  input  wire logic               io3_i,
  output logic                    io3_o,
  output logic                    io3_oe,
  // observation
  output fpc_pkg::fpc_role_type   shared_role,
  output logic                    hw_reset_active
);
  import fpc_pkg::*;

  // ==========================================================================
  // pin synchronisers
  logic [6:0] pins_s;
  logic       ce_n_s;
  logic       sck_s;
  logic       rstpin_n_s;
  logic [3:0] io_s;
  logic       sck_d_r;

  fpc_sync #(
    .WIDTH (7),
    .INIT  (7'h7f)
  ) u_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .async_in ({io3_i, io2_i, io1_i, io0_i, hw_reset_n, sck, ce_n}),
    .sync_out (pins_s)
  );

  assign ce_n_s     = pins_s[0];
  assign sck_s      = pins_s[1];
  assign rstpin_n_s = pins_s[2];
  assign io_s       = pins_s[6:3];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sck_d_r <= 1'b1; // same level as the synchroniser reset, so no false edge
    end else begin
      sck_d_r <= sck_s;
    end
  end

  // ==========================================================================
  // registers
  logic [7:0] status_r;
  logic [1:0] config_r;
  logic [7:0] tx_data_r;
  logic [7:0] rx_data_r;
  logic       refused_r;
  logic       rx_valid_r;

  logic       quad_enable;
  logic       status_write_disable;
  logic       pin_function_select;
  logic       write_protected;
  logic       wb_req;
  logic       wb_wr;
  logic       hit_status;
  logic       hit_pinstat;
  logic       hit_config;
  logic       hit_txdata;
  logic       refuse_evt;
  logic       rx_done;

  assign quad_enable          = status_r[`FPC_ST_QE];
  assign status_write_disable = status_r[`FPC_ST_SWD];
  assign pin_function_select  = config_r[`FPC_CF_PFS];

  // protect pin only counts while it is not a data line
  assign write_protected = status_write_disable & ~io_s[2] & ~quad_enable;

  assign wb_req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr       = wb_req & wb_we_i & wb_sel_i[0];
  assign hit_status  = wb_adr_i == `FPC_OFS_STATUS;
  assign hit_config  = wb_adr_i == `FPC_OFS_CONFIG;
  assign hit_txdata  = wb_adr_i == `FPC_OFS_TXDATA;
  assign hit_pinstat = wb_adr_i == `FPC_OFS_PINSTAT;
  assign refuse_evt  = wb_wr & hit_status & write_protected;

  // ==========================================================================
  // status register: only the protectable field is writable here
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_r <= `FPC_ST_RST;
    end else if (wb_wr && hit_status && !write_protected) begin
      status_r[`FPC_ST_SWD:`FPC_ST_BP_LO] <= wb_dat_i[`FPC_ST_SWD:`FPC_ST_BP_LO];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      config_r <= `FPC_CF_RST;
    end else if (wb_wr && hit_config) begin
      config_r <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_data_r <= `FPC_TX_RST;
    end else if (wb_wr && hit_txdata) begin
      tx_data_r <= wb_dat_i[7:0];
    end
  end

  // sticky flags: write one clears, a new event in the same cycle wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      refused_r  <= 1'b0;
      rx_valid_r <= 1'b0;
    end else begin
      refused_r  <= (refused_r & ~(wb_wr & hit_pinstat & wb_dat_i[`FPC_PS_REFUSED]))
                    | refuse_evt;
      rx_valid_r <= (rx_valid_r & ~(wb_wr & hit_pinstat & wb_dat_i[`FPC_PS_RXVALID]))
                    | rx_done;
    end
  end

  // ==========================================================================
  // shared pin role and pin functions
  fpc_role_type role_now;
  logic         pause_act;
  logic         selected;

  always_comb begin
    if (quad_enable) begin
      role_now = FPC_ROLE_DATA3;
    end else if (SEPARATE_RESET_PIN || !pin_function_select) begin
      role_now = FPC_ROLE_PAUSE;
    end else begin
      role_now = FPC_ROLE_RESET;
    end
  end

  assign shared_role     = role_now;
  assign selected        = ~ce_n_s;
  assign pause_act       = (role_now == FPC_ROLE_PAUSE) & ~io_s[3] & selected;
  // the separate pin resets regardless of quad enable and the select bit
  assign hw_reset_active = ((role_now == FPC_ROLE_RESET) & ~io_s[3])
                           | (SEPARATE_RESET_PIN & ~rstpin_n_s);

  // ==========================================================================
  // serial engine
  fpc_ser_type ser_r;
  logic [7:0]  rx_sh_r;
  logic [7:0]  tx_sh_r;
  logic [2:0]  bit_cnt_r;
  logic        launch_pend_r;
  logic        reload_pend_r;
  logic [3:0]  out_r;
  logic [3:0]  oe_r;
  logic        sck_rise;
  logic        sck_fall;
  logic        engine_run;
  logic [2:0]  step;
  logic [7:0]  rx_next;

  // pause masks the clock so a frozen transfer resumes on the same bit
  assign engine_run = selected & ~pause_act & ~hw_reset_active;
  assign sck_rise   = engine_run & sck_s & ~sck_d_r;
  assign sck_fall   = engine_run & ~sck_s & sck_d_r;
  assign step       = quad_enable ? 3'h4 : 3'h1;
  assign rx_next    = quad_enable ? {rx_sh_r[3:0], io_s} : {rx_sh_r[6:0], io_s[0]};
  assign rx_done    = sck_rise & (bit_cnt_r == 3'(`FPC_BYTE_BITS - step));

  always_ff @(posedge clk_sys) begin
    if (rst || hw_reset_active || !selected) begin
      ser_r <= FPC_SER_IDLE;
    end else begin
      case (ser_r)
        FPC_SER_IDLE:  ser_r <= pause_act ? FPC_SER_PAUSE : FPC_SER_SHIFT;
        FPC_SER_SHIFT: ser_r <= pause_act ? FPC_SER_PAUSE : FPC_SER_SHIFT;
        FPC_SER_PAUSE: ser_r <= pause_act ? FPC_SER_PAUSE : FPC_SER_SHIFT;
        default:       ser_r <= FPC_SER_IDLE;
      endcase
    end
  end

  // input side: bit count and receive shifter
  always_ff @(posedge clk_sys) begin
    if (rst || hw_reset_active || !selected) begin
      bit_cnt_r <= 3'h0;
      rx_sh_r   <= 8'h00;
    end else if (sck_rise) begin
      rx_sh_r   <= rx_next;
      bit_cnt_r <= bit_cnt_r + step;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_data_r <= 8'h00;
    end else if (rx_done) begin
      rx_data_r <= rx_next;
    end
  end

  // output side: a falling edge only launches after a rising edge was seen,
  // so the idle-high clock of mode 3 does not skip the first bit
  always_ff @(posedge clk_sys) begin
    if (rst || hw_reset_active || !selected) begin
      tx_sh_r       <= tx_data_r;
      launch_pend_r <= 1'b0;
      reload_pend_r <= 1'b0;
    end else if (sck_rise) begin
      launch_pend_r <= 1'b1;
      reload_pend_r <= rx_done;
    end else if (sck_fall && launch_pend_r) begin
      launch_pend_r <= 1'b0;
      if (reload_pend_r) begin
        tx_sh_r <= tx_data_r;
      end else begin
        tx_sh_r <= quad_enable ? {tx_sh_r[3:0], 4'h0} : {tx_sh_r[6:0], 1'b0};
      end
    end
  end

  // pad drivers: enables drop during pause, reset and deselect
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_r <= 4'h0;
      oe_r  <= 4'h0;
    end else begin
      out_r <= quad_enable ? tx_sh_r[7:4] : {2'b00, tx_sh_r[7], 1'b0};
      if (!engine_run || !config_r[`FPC_CF_DRIVE]) begin
        oe_r <= 4'h0;
      end else if (quad_enable) begin
        oe_r <= 4'hf;
      end else begin
        oe_r <= 4'h2;
      end
    end
  end

  assign io0_o  = out_r[0];
  assign io1_o  = out_r[1];
  assign io2_o  = out_r[2];
  assign io3_o  = out_r[3];
  assign io0_oe = oe_r[0];
  assign io1_oe = oe_r[1];
  assign io2_oe = oe_r[2];
  assign io3_oe = oe_r[3];

  // ==========================================================================
  // wishbone read and acknowledge: one wait state, unmapped reads zero
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      `FPC_OFS_STATUS:  rd_mux[7:0] = status_r;
      `FPC_OFS_CONFIG:  rd_mux[1:0] = config_r;
      `FPC_OFS_TXDATA:  rd_mux[7:0] = tx_data_r;
      `FPC_OFS_RXDATA:  rd_mux[7:0] = rx_data_r;
      `FPC_OFS_PINSTAT: begin
        rd_mux[`FPC_PS_SEL]     = selected;
        rd_mux[`FPC_PS_PAUSE]   = (ser_r == FPC_SER_PAUSE);
        rd_mux[`FPC_PS_HWRST]   = hw_reset_active;
        rd_mux[`FPC_PS_REFUSED] = refused_r;
        rd_mux[`FPC_PS_RXVALID] = rx_valid_r;
        rd_mux[`FPC_PS_ROLE_HI:`FPC_PS_ROLE_LO] = role_now;
      end
      default:          rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

endmodule // fpc_pin_function

// >>> tb/fpc_pin_function_properties.sv
// fpc_pin_function_properties.sv - port checks of the pin function block.
// assumes it is bound into fpc_pin_function; one clock, synchronous reset.
`timescale 1ns/1ps
module fpc_pin_function_properties
  import fpc_pkg::*;
#(parameter bit SEPARATE_RESET_PIN = 1'b0) (
  // clock and bus
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_we_i,
  input wire logic                  wb_ack_o,
  // pins
  input wire logic                  ce_n,
  input wire logic                  sck,
  input wire logic                  io3_i,
  input wire logic                  io1_o,
  input wire logic                  io0_oe,
  input wire logic                  io1_oe,
  input wire logic                  io2_oe,
  input wire logic                  io3_oe,
  input wire fpc_pkg::fpc_role_type shared_role,
  input wire logic                  hw_reset_active
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic drv;
  assign drv = io0_oe | io1_oe | io2_oe | io3_oe;
  // =========
  // checks
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked in the next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_role_on_write: assert property ($changed(shared_role) |-> wb_ack_o && wb_we_i)
    else $error("pin role moved without a register write");
  a_deselect_float: assert property (ce_n [*5] |-> !drv)
    else $error("pin driven while deselected");
  a_hwrst_float: assert property (hw_reset_active [*2] |-> !drv)
    else $error("pin driven during hardware reset");
  a_pause_float: assert property ((!ce_n && !io3_i && shared_role == FPC_ROLE_PAUSE) [*5]
    |-> !io1_oe)
    else $error("serial output driven while paused");
  a_reset_needs_role: assert property (shared_role != FPC_ROLE_RESET && !SEPARATE_RESET_PIN
    |-> !hw_reset_active)
    else $error("hardware reset outside the reset role");
  a_reset_pin_level: assert property ((shared_role == FPC_ROLE_RESET && !io3_i) [*3]
    |-> hw_reset_active)
    else $error("reset role pin low without reset");
  // launches follow falling edges only, so a high clock phase holds the output
  a_high_phase_hold: assert property (!ce_n && !$past(ce_n, 8) && sck && $past(sck)
    |-> $stable(io1_o))
    else $error("serial output moved in a high clock phase");
  c_hw_reset: cover property (hw_reset_active);
  c_quad_role: cover property (shared_role == FPC_ROLE_DATA3);
  c_paused: cover property (!ce_n && !io3_i && shared_role == FPC_ROLE_PAUSE);
endmodule // fpc_pin_function_properties

bind fpc_pin_function fpc_pin_function_properties #(
  .SEPARATE_RESET_PIN(SEPARATE_RESET_PIN)) u_props (
  .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .ce_n(ce_n), .sck(sck), .io3_i(io3_i),
  .io1_o(io1_o), .io0_oe(io0_oe), .io1_oe(io1_oe), .io2_oe(io2_oe), .io3_oe(io3_oe),
  .shared_role(shared_role), .hw_reset_active(hw_reset_active));

// >>> tb/fpc_spi_host.sv
// fpc_spi_host.sv - behavioural spi host driving the flash pins of the block.
// assumes the bench resolves the io1 wire and chooses the protect and pin3 levels.
`timescale 1ns/1ps
module fpc_spi_host (
  // levels chosen by the bench
  input wire logic wp_lvl,
  input wire logic pin3_lvl,
  // flash pins
  input wire logic io1,
  output logic     ce_n,
  output logic     sck,
  output logic     io0,
  output logic     io2,
  output logic     io3
);
  logic hold_r;
  initial begin
    ce_n = 1'b1;
    sck = 1'b0;
    io0 = 1'b0;
    hold_r = 1'b0;
  end
  assign io2 = wp_lvl;
  // pin3 level moves between frames; hold_r pulls it low inside a frame for a pause
  assign io3 = pin3_lvl & ~hold_r;
  // =========
  // one byte, modes 0 and 3; sck stands still outside the frame
  // selects or deselects with no clock, off the system clock edge
  task automatic select(input bit s);
    #2 ce_n = ~s;
  endtask
  task automatic xfer(input bit m3, input bit sel, input int hold_at,
                      input logic [7:0] tx, output logic [7:0] rx);
    #2 sck = m3;
    #20 ce_n = ~sel;
    #80;
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      io0 = tx[i];
      if (i == hold_at) begin
        #50 hold_r = 1'b1;
        #100 sck = 1'b1;
        #62.5 sck = 1'b0;
        #100 hold_r = 1'b0;
      end
      #62.5 sck = 1'b1;
      rx[i] = io1;
      #62.5;
    end
    sck = m3;
    #40 ce_n = 1'b1;
    io0 = ~io0;
  endtask
endmodule // fpc_spi_host

// >>> tb/testbench.sv
// testbench.sv - register and link tests of the pin function block.
// assumes fpc_spi_host as the far side and the bound property checker.
`timescale 1ns/1ps
`include "fpc_cfg.svh"
module testbench;
  import fpc_pkg::*;
  logic         clk_sys = 1'b0, rst = 1'b1;
  logic         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]   wb_adr_i = 8'h00, st, rx;
  logic [3:0]   wb_sel_i = 4'hf;
  logic [31:0]  wb_dat_i = 32'h0, wb_dat_o, q, d;
  logic         wb_ack_o, ce_n, sck, h_io0, h_io2, h_io3, io1_last = 1'b0;
  logic         io0_o, io0_oe, io1_o, io1_oe, io2_o, io2_oe, io3_o, io3_oe;
  logic         io0_w, io1_w, io2_w, io3_w, wp_lvl = 1'b1, pin3_lvl = 1'b1;
  logic         hw_reset_active, refused, sep_rst_lvl = 1'b1, hw_reset_active_sep;
  fpc_role_type shared_role, role_exp, shared_role_sep;
  int           mismatches = 0, tests_run = 0, seed = 32'hcf3ed4f3;
  always #4 clk_sys = ~clk_sys;
  // a released line shows the inverse of its last level, never a kind guess
  always @(posedge clk_sys) if (io1_oe) io1_last <= io1_o;
  assign io0_w = io0_oe ? io0_o : h_io0;
  assign io1_w = io1_oe ? io1_o : ~io1_last;
  assign io2_w = io2_oe ? io2_o : h_io2;
  assign io3_w = io3_oe ? io3_o : h_io3;
  fpc_pin_function dut (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ce_n(ce_n), .sck(sck),
    .hw_reset_n(sep_rst_lvl),
    .io0_i(io0_w), .io0_o(io0_o), .io0_oe(io0_oe), .io1_i(io1_w), .io1_o(io1_o),
    .io1_oe(io1_oe), .io2_i(io2_w), .io2_o(io2_o), .io2_oe(io2_oe), .io3_i(io3_w),
    .io3_o(io3_o), .io3_oe(io3_oe), .shared_role(shared_role),
    .hw_reset_active(hw_reset_active));
  fpc_spi_host host (.wp_lvl(wp_lvl), .pin3_lvl(pin3_lvl), .io1(io1_w), .ce_n(ce_n),
    .sck(sck), .io0(h_io0), .io2(h_io2), .io3(h_io3));
  // variant with a dedicated reset pin; only its role and reset outputs are watched
  fpc_pin_function #(.SEPARATE_RESET_PIN(1'b1)) dut_sep (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(), .wb_ack_o(), .ce_n(ce_n), .sck(sck), .hw_reset_n(sep_rst_lvl),
    .io0_i(io0_w), .io0_o(), .io0_oe(), .io1_i(io1_w), .io1_o(), .io1_oe(),
    .io2_i(io2_w), .io2_o(), .io2_oe(), .io3_i(io3_w), .io3_o(), .io3_oe(),
    .shared_role(shared_role_sep), .hw_reset_active(hw_reset_active_sep));
  // =========
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb_io(input logic we, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= v;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk({31'h0, wb_ack_o}, 32'h1);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200_000;
    mismatches++;
    tally_and_finish();
  end
  // =========
  // tests
  initial begin
    st = 8'h00;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      d = $random(seed);
      wp_lvl <= d[8];
      pin3_lvl <= d[9];
      sep_rst_lvl <= d[12];
      repeat (4) @(posedge clk_sys);
      refused = st[7] && !d[8] && !st[6];
      if (!refused) st = d[7:0] & 8'hfc;
      wb_io(1'b1, `FPC_OFS_STATUS, d);
      wb_io(1'b1, `FPC_OFS_CONFIG, {31'h0, d[10]});
      wb_io(1'b0, `FPC_OFS_STATUS, 32'h0);
      chk(q & 32'hff, {24'h0, st});
      wb_io(1'b0, `FPC_OFS_PINSTAT, 32'h0);
      chk(q & 32'h8, refused ? 32'h8 : 32'h0);
      role_exp = st[6] ? FPC_ROLE_DATA3 : (d[10] ? FPC_ROLE_RESET : FPC_ROLE_PAUSE);
      chk({30'h0, shared_role}, {30'h0, role_exp});
      chk({31'h0, hw_reset_active}, {31'h0, role_exp == FPC_ROLE_RESET && !d[9]});
      chk({30'h0, shared_role_sep}, {30'h0, st[6] ? FPC_ROLE_DATA3 : FPC_ROLE_PAUSE});
      chk({31'h0, hw_reset_active_sep}, {31'h0, !d[12]});
      wb_io(1'b1, `FPC_OFS_PINSTAT, 32'h18);
    end
    $display("test registers done");
    wp_lvl <= 1'b1;
    pin3_lvl <= 1'b1;
    sep_rst_lvl <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wb_io(1'b0, `FPC_OFS_STATUS, 32'h0);
    chk(q, {24'h0, `FPC_ST_RST});
    wb_io(1'b0, `FPC_OFS_CONFIG, 32'h0);
    chk(q, {30'h0, `FPC_CF_RST});
    wb_io(1'b0, `FPC_OFS_TXDATA, 32'h0);
    chk(q, {24'h0, `FPC_TX_RST});
    chk({30'h0, shared_role}, {30'h0, FPC_ROLE_PAUSE});
    $display("test reset done");
    wb_io(1'b1, `FPC_OFS_STATUS, 32'h0);
    wb_io(1'b1, `FPC_OFS_CONFIG, 32'h2);
    for (int i = 0; i < 5; i++) begin
      d = $random(seed);
      wb_io(1'b1, `FPC_OFS_TXDATA, {24'h0, d[7:0]});
      host.xfer(i[0], i < 4, i[1] ? int'(d[10:8]) : -1, d[23:16], rx);
      repeat (8) @(posedge clk_sys);
      wb_io(1'b0, `FPC_OFS_PINSTAT, 32'h0);
      chk(q & 32'h10, i < 4 ? 32'h10 : 32'h0);
      if (i < 4) begin
        chk({24'h0, rx}, {24'h0, d[7:0]});
        wb_io(1'b0, `FPC_OFS_RXDATA, 32'h0);
        chk(q & 32'hff, {24'h0, d[23:16]});
      end
      wb_io(1'b1, `FPC_OFS_PINSTAT, 32'h18);
    end
    $display("test link done");
    d = $random(seed);
    wb_io(1'b1, `FPC_OFS_STATUS, 32'h40);
    wb_io(1'b1, `FPC_OFS_TXDATA, {24'h0, d[7:0]});
    host.select(1'b1);
    repeat (8) @(posedge clk_sys);
    chk({28'h0, io3_oe, io2_oe, io1_oe, io0_oe}, 32'hf);
    chk({28'h0, io3_w, io2_w, io1_w, io0_w}, {28'h0, d[7:4]});
    chk({30'h0, shared_role}, {30'h0, FPC_ROLE_DATA3});
    host.select(1'b0);
    repeat (8) @(posedge clk_sys);
    chk({28'h0, io3_oe, io2_oe, io1_oe, io0_oe}, 32'h0);
    $display("test quad done");
    tally_and_finish();
  end
endmodule // testbench
